// >>> inc/sbp_pkg.sv
// How it works
// - buffer miss means direction comes from the fixed static rules, except a conditional in alternative mode
// - buffer miss gives no dynamic prediction unless alternative mode sees a conditional; otherwise static path decides alone
// - static: unconditional branches and calls predicted taken to target
// - static: conditional branch with lower target predicted taken
// - static: conditional branch with higher target predicted not taken
// - static: indirect branch predicted not taken, fetch falls through
// - conditional branch never taken gets no buffer entry
// - every taken branch takes a buffer entry, competing for capacity
// - alternative mode predicts all conditionals dynamically, no direction
package sbp_pkg;
  localparam int ADDR_W = 32;
  localparam int IDX_W = 4;
  localparam int ENTRIES = 16;
  localparam int TAG_W = ADDR_W - IDX_W;
  localparam int CTR_W = 2;
  localparam logic [CTR_W-1:0] CTR_RESET = 2'h0;
  localparam logic [CTR_W-1:0] CTR_ALLOC = 2'h2;
  localparam logic [CTR_W-1:0] CTR_MAX = 2'h3;
  localparam logic [CTR_W-1:0] CTR_MIN = 2'h0;
  localparam logic [CTR_W-1:0] CTR_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0;
  localparam logic [ADDR_W-1:0] ALIGN_DEFAULT = 32'h4;

  typedef enum logic [1:0] {
    SBP_BR_UNCOND,
    SBP_BR_COND,
    SBP_BR_INDIRECT,
    SBP_BR_NONE
  } sbp_br_t;

  typedef enum logic [1:0] {
    SBP_SRC_NONE,
    SBP_SRC_STATIC,
    SBP_SRC_DYNAMIC
  } sbp_src_t;
endpackage

// >>> design/sbp_predictor.sv
`timescale 1ns/1ns
module sbp_predictor (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // mode: high predicts every conditional branch dynamically
  input wire logic dyn_all_i,
  // lookup from decode
  input wire logic lookup_valid_i,
  input wire logic [sbp_pkg::ADDR_W-1:0] lookup_pc_i,
  input wire logic [sbp_pkg::ADDR_W-1:0] lookup_next_pc_i,
  input wire logic [sbp_pkg::ADDR_W-1:0] lookup_target_i,
  input wire sbp_pkg::sbp_br_t lookup_kind_i,
  // resolution from execute
  input wire logic resolve_valid_i,
  input wire logic [sbp_pkg::ADDR_W-1:0] resolve_pc_i,
  input wire logic [sbp_pkg::ADDR_W-1:0] resolve_target_i,
  input wire sbp_pkg::sbp_br_t resolve_kind_i,
  input wire logic resolve_taken_i,
  // prediction to fetch
  output logic pred_valid_o,
  output logic pred_taken_o,
  output logic [sbp_pkg::ADDR_W-1:0] pred_pc_o,
  output sbp_pkg::sbp_src_t pred_src_o,
  output logic pred_hit_o
);
  import sbp_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ENTRIES-1:0] valid;
    logic [ENTRIES-1:0][TAG_W-1:0] tag;
    logic [ENTRIES-1:0][ADDR_W-1:0] target;
    logic [ENTRIES-1:0][CTR_W-1:0] ctr;
    logic pred_valid;
    logic pred_taken;
    logic [ADDR_W-1:0] pred_pc;
    sbp_src_t pred_src;
    logic pred_hit;
  } sbp_state_t;

  sbp_state_t s_q;
  sbp_state_t s_d;
  logic rst_meta_q;
  logic rst_sync_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // buffer slot from the low address bits
  function automatic logic [IDX_W-1:0] sbp_index(
    input logic [ADDR_W-1:0] pc);
    sbp_index = pc[IDX_W-1:0];
  endfunction

  // tag keeps the rest, so aliases in one slot never share a hit
  function automatic logic [TAG_W-1:0] sbp_tag(
    input logic [ADDR_W-1:0] pc);
    sbp_tag = pc[ADDR_W-1:IDX_W];
  endfunction

  // a slot hits only when it is valid and its tag matches
  function automatic logic sbp_hit(
    input logic vld,
    input logic [TAG_W-1:0] tag,
    input logic [ADDR_W-1:0] pc);
    sbp_hit = vld && tag == sbp_tag(pc);
  endfunction

  // fixed fallback direction for a branch without history
  function automatic logic sbp_static_dir(
    input sbp_br_t kind,
    input logic [ADDR_W-1:0] pc,
    input logic [ADDR_W-1:0] target);
    logic bwd;
    // equal target counts as forward
    bwd = target < pc;
    case (kind)
      SBP_BR_UNCOND: sbp_static_dir = 1'b1;
      SBP_BR_COND: sbp_static_dir = bwd;
      SBP_BR_INDIRECT: sbp_static_dir = 1'b0;
      default: sbp_static_dir = 1'b0;
    endcase
  endfunction

  // two-bit confidence counter, saturating at both ends
  function automatic logic [CTR_W-1:0] sbp_ctr_step(
    input logic [CTR_W-1:0] ctr,
    input logic taken);
    sbp_ctr_step = ctr;
    if (taken) begin
      if (ctr != CTR_MAX) begin
        sbp_ctr_step = ctr + CTR_ONE;
      end
    end else begin
      if (ctr != CTR_MIN) begin
        sbp_ctr_step = ctr - CTR_ONE;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // the copy lets go two edges after the pin, on a clean clock edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // lookup and update
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] l_idx;
  logic [IDX_W-1:0] r_idx;
  logic l_hit;
  logic r_hit;
  logic static_taken;

  always_comb begin
    l_idx = sbp_index(lookup_pc_i);
    r_idx = sbp_index(resolve_pc_i);
    l_hit = sbp_hit(s_q.valid[l_idx], s_q.tag[l_idx], lookup_pc_i);
    r_hit = sbp_hit(s_q.valid[r_idx], s_q.tag[r_idx], resolve_pc_i);
    static_taken = sbp_static_dir(lookup_kind_i, lookup_pc_i,
                                  lookup_target_i);

    // prediction: a lookup sees the buffer as it was before this edge
    s_d = s_q;
    s_d.pred_valid = lookup_valid_i && lookup_kind_i != SBP_BR_NONE;
    s_d.pred_hit = l_hit;
    s_d.pred_taken = 1'b0;
    s_d.pred_pc = lookup_next_pc_i;
    s_d.pred_src = SBP_SRC_NONE;
    if (s_d.pred_valid) begin
      if (l_hit) begin
        // dynamic direction and stored target win
        s_d.pred_src = SBP_SRC_DYNAMIC;
        s_d.pred_taken = s_q.ctr[l_idx][CTR_W-1];
        if (s_d.pred_taken) begin
          s_d.pred_pc = s_q.target[l_idx];
        end
      end else if (dyn_all_i && lookup_kind_i == SBP_BR_COND) begin
        // first sight, direction ignored: weak not-taken default
        s_d.pred_src = SBP_SRC_DYNAMIC;
        s_d.pred_taken = 1'b0;
      end else begin
        // miss: buffer silent, static path decides
        s_d.pred_src = SBP_SRC_STATIC;
        s_d.pred_taken = static_taken;
        if (static_taken) begin
          s_d.pred_pc = lookup_target_i;
        end
      end
    end

    // training: resolved branches update the buffer
    if (resolve_valid_i && resolve_kind_i != SBP_BR_NONE) begin
      if (r_hit) begin
        s_d.target[r_idx] = resolve_taken_i ? resolve_target_i
                                            : s_q.target[r_idx];
        s_d.ctr[r_idx] = sbp_ctr_step(s_q.ctr[r_idx], resolve_taken_i);
      end else if (resolve_taken_i) begin
        // taken branch evicts whatever shares its slot
        s_d.valid[r_idx] = 1'b1;
        s_d.tag[r_idx] = sbp_tag(resolve_pc_i);
        s_d.target[r_idx] = resolve_target_i;
        s_d.ctr[r_idx] = CTR_ALLOC;
      end
      // a not-taken miss leaves the buffer untouched
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q.valid <= '0;
      s_q.tag <= '0;
      s_q.target <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        s_q.ctr[i] <= CTR_RESET;
      end
      s_q.pred_valid <= 1'b0;
      s_q.pred_taken <= 1'b0;
      s_q.pred_pc <= ADDR_ZERO;
      s_q.pred_src <= SBP_SRC_NONE;
      s_q.pred_hit <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pred_valid_o = s_q.pred_valid;
  assign pred_taken_o = s_q.pred_taken;
  assign pred_pc_o = s_q.pred_pc;
  assign pred_src_o = s_q.pred_src;
  assign pred_hit_o = s_q.pred_hit;
endmodule

// >>> test/sbp_checker.sv
`timescale 1ns/1ns
module sbp_checker import sbp_pkg::*; (
  input wire logic clk_i, reset_n_i, dyn_all_i, lookup_valid_i,
  input wire logic resolve_valid_i, resolve_taken_i, pred_valid_o,
  input wire logic pred_taken_o, pred_hit_o,
  input wire logic [ADDR_W-1:0] lookup_pc_i, lookup_next_pc_i,
  input wire logic [ADDR_W-1:0] lookup_target_i, resolve_pc_i, pred_pc_o,
  input wire sbp_br_t lookup_kind_i, resolve_kind_i,
  input wire sbp_src_t pred_src_o
);
  logic [1:0] up_q;
  logic v;
  logic c;
  // lookups count once the internal reset copy has let go
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  assign v = lookup_valid_i && up_q == 2'h3;
  assign c = v && lookup_kind_i == SBP_BR_COND && !dyn_all_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  unc_a: assert property (
    v && lookup_kind_i == SBP_BR_UNCOND |=> pred_hit_o || pred_taken_o
    && pred_pc_o == $past(lookup_target_i)) else $error("bad uncond");
  bwd_a: assert property (
    c && lookup_target_i < lookup_pc_i |=> pred_hit_o || pred_taken_o)
    else $error("bad backward");
  fwd_a: assert property (
    c && lookup_target_i >= lookup_pc_i |=> pred_hit_o || !pred_taken_o
    && pred_pc_o == $past(lookup_next_pc_i)) else $error("bad forward");
  ind_a: assert property (
    v && lookup_kind_i == SBP_BR_INDIRECT |=> pred_hit_o || !pred_taken_o
    && pred_pc_o == $past(lookup_next_pc_i)) else $error("bad indirect");
  mis_a: assert property (
    pred_valid_o && !pred_hit_o && !$past(dyn_all_i)
    |-> pred_src_o == SBP_SRC_STATIC) else $error("bad miss source");
  alt_a: assert property (
    v && dyn_all_i && lookup_kind_i == SBP_BR_COND
    |=> pred_src_o == SBP_SRC_DYNAMIC) else $error("bad alt mode");
  hit_a: assert property (
    pred_valid_o && pred_hit_o |-> pred_src_o == SBP_SRC_DYNAMIC)
    else $error("bad hit source");
  alc_a: assert property (
    resolve_valid_i && resolve_taken_i && resolve_kind_i != SBP_BR_NONE
    ##1 v && lookup_kind_i != SBP_BR_NONE
    && lookup_pc_i == $past(resolve_pc_i) |=> pred_hit_o)
    else $error("taken branch not held");
  cover property (c && lookup_target_i < lookup_pc_i);
  cover property (pred_valid_o && pred_hit_o);
  cover property (v && dyn_all_i);
endmodule
bind sbp_predictor sbp_checker chk (.*);

// >>> test/sbp_fetch_model.sv
`timescale 1ns/1ns
module sbp_fetch_model import sbp_pkg::*; (
  input wire logic clk_i,
  output logic lookup_valid_i, resolve_valid_i, resolve_taken_i,
  output logic [ADDR_W-1:0] lookup_pc_i, lookup_next_pc_i, lookup_target_i,
  output logic [ADDR_W-1:0] resolve_pc_i, resolve_target_i,
  output sbp_br_t lookup_kind_i, resolve_kind_i
);
  initial begin
    {lookup_valid_i, resolve_valid_i, resolve_taken_i} = 3'h0;
    {lookup_pc_i, lookup_next_pc_i, lookup_target_i} = 96'h0;
    {resolve_pc_i, resolve_target_i} = 64'h0;
    lookup_kind_i = SBP_BR_NONE;
    resolve_kind_i = SBP_BR_NONE;
  end
  task automatic look(input sbp_br_t k, input logic [ADDR_W-1:0] pc, t);
    @(negedge clk_i);
    {lookup_valid_i, lookup_pc_i, lookup_target_i} = {1'b1, pc, t};
    lookup_kind_i = k;
    lookup_next_pc_i = pc + ALIGN_DEFAULT;
    @(negedge clk_i);
    lookup_valid_i = 1'b0;
    // released fields flip so stale values never pass for live ones
    {lookup_pc_i, lookup_target_i} = ~{lookup_pc_i, lookup_target_i};
  endtask
  task automatic res(input sbp_br_t k, input logic [ADDR_W-1:0] pc, t,
    input logic tk);
    @(negedge clk_i);
    {resolve_valid_i, resolve_pc_i, resolve_target_i} = {1'b1, pc, t};
    resolve_kind_i = k;
    resolve_taken_i = tk;
    @(negedge clk_i);
    resolve_valid_i = 1'b0;
    {resolve_pc_i, resolve_target_i} = ~{resolve_pc_i, resolve_target_i};
  endtask
  // taken resolve, then a lookup of the same branch on the next edge
  task automatic res_look(input sbp_br_t k, input logic [ADDR_W-1:0] pc, t);
    @(negedge clk_i);
    {resolve_valid_i, resolve_pc_i, resolve_target_i} = {1'b1, pc, t};
    resolve_kind_i = k;
    resolve_taken_i = 1'b1;
    @(negedge clk_i);
    resolve_valid_i = 1'b0;
    {lookup_valid_i, lookup_pc_i, lookup_target_i} = {1'b1, pc, t};
    lookup_kind_i = k;
    lookup_next_pc_i = pc + ALIGN_DEFAULT;
    @(negedge clk_i);
    lookup_valid_i = 1'b0;
  endtask
endmodule

// >>> test/sbp_predictor_tb_top.sv
`timescale 1ns/1ns
module sbp_predictor_tb_top;
  import sbp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic dyn_all_i = 1'b0;
  logic lookup_valid_i, resolve_valid_i, resolve_taken_i;
  logic pred_valid_o, pred_taken_o, pred_hit_o;
  logic [ADDR_W-1:0] lookup_pc_i, lookup_next_pc_i, lookup_target_i;
  logic [ADDR_W-1:0] resolve_pc_i, resolve_target_i, pred_pc_o;
  sbp_br_t lookup_kind_i, resolve_kind_i;
  sbp_src_t pred_src_o;
  int errors = 0;
  int n_checks = 0;
  always #20 clk_i = ~clk_i;
  sbp_fetch_model fm (.*);
  sbp_predictor uut (.*);
  task chk(input string n, input logic [36:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task p(input sbp_br_t k, input logic [ADDR_W-1:0] pc, t,
    input logic tk, input sbp_src_t s, input logic h);
    fm.look(k, pc, t);
    chk("pred", {pred_valid_o, pred_taken_o, pred_pc_o, pred_src_o,
      pred_hit_o}, {1'b1, tk, tk ? t : pc + ALIGN_DEFAULT, s, h});
  endtask
  task t_static;
    p(SBP_BR_UNCOND, 32'h100, 32'h800, 1'b1, SBP_SRC_STATIC, 1'b0);
    p(SBP_BR_COND, 32'h200, 32'h1F0, 1'b1, SBP_SRC_STATIC, 1'b0);
    p(SBP_BR_COND, 32'h300, 32'h340, 1'b0, SBP_SRC_STATIC, 1'b0);
    p(SBP_BR_COND, 32'h400, 32'h400, 1'b0, SBP_SRC_STATIC, 1'b0);
    p(SBP_BR_INDIRECT, 32'h500, 32'h10, 1'b0, SBP_SRC_STATIC, 1'b0);
    fm.look(SBP_BR_NONE, 32'h600, 32'h0);
    chk("valid", {36'h0, pred_valid_o}, 37'h0);
  endtask
  task t_alloc;
    fm.res(SBP_BR_COND, 32'h700, 32'h780, 1'b0);
    p(SBP_BR_COND, 32'h700, 32'h780, 1'b0, SBP_SRC_STATIC, 1'b0);
    fm.res(SBP_BR_COND, 32'h708, 32'h7C0, 1'b1);
    p(SBP_BR_COND, 32'h708, 32'h7C0, 1'b1, SBP_SRC_DYNAMIC, 1'b1);
    fm.res(SBP_BR_UNCOND, 32'h718, 32'h900, 1'b1);
    p(SBP_BR_COND, 32'h708, 32'h7C0, 1'b0, SBP_SRC_STATIC, 1'b0);
    fm.res_look(SBP_BR_COND, 32'h70C, 32'h680);
    chk("alloc", {pred_valid_o, pred_taken_o, pred_pc_o, pred_src_o,
      pred_hit_o}, {1'b1, 1'b1, 32'h680, SBP_SRC_DYNAMIC, 1'b1});
    fm.res(SBP_BR_COND, 32'h70C, 32'h680, 1'b0);
    fm.res(SBP_BR_COND, 32'h70C, 32'h680, 1'b0);
    p(SBP_BR_COND, 32'h70C, 32'h680, 1'b0, SBP_SRC_DYNAMIC, 1'b1);
  endtask
  task t_alt;
    dyn_all_i = 1'b1;
    p(SBP_BR_COND, 32'hA00, 32'h9F0, 1'b0, SBP_SRC_DYNAMIC, 1'b0);
    p(SBP_BR_COND, 32'hB00, 32'hB40, 1'b0, SBP_SRC_DYNAMIC, 1'b0);
    p(SBP_BR_UNCOND, 32'hC00, 32'hD00, 1'b1, SBP_SRC_STATIC, 1'b0);
    dyn_all_i = 1'b0;
  endtask
  task results;
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_static;
    t_alloc;
    t_alt;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
